// ---- core/test_point_strap_debug_port.sv ----
// Test point port: reset strap capture and debug output selection
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module test_point_strap_debug_port #(
  parameter int ACC_W = 24
) (
  // Clock and system reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Test point pins
  input  wire logic [7:0]           test_point_port_i,
  output tp_pkg::tp_drive_type      test_point_port,
  output logic      [7:0]           pull_down_en,
  // Strap results
  output logic      [3:0]           mode_option,
  output logic                      strap_valid
);

  if (ACC_W < 8 || ACC_W > 31) begin : g_bad_acc
    $error("ACC_W must lie between 8 and 31");
  end

  //--------------------------------------------------
  // Constants
  //--------------------------------------------------
  localparam logic [ACC_W-1:0] INC0 =
    ACC_W'(tp_pkg::nco_inc(tp_pkg::CLK0_HZ, ACC_W));
  localparam logic [ACC_W-1:0] INC1 =
    ACC_W'(tp_pkg::nco_inc(tp_pkg::CLK1_HZ, ACC_W));
  localparam logic [ACC_W-1:0] INC7 =
    ACC_W'(tp_pkg::nco_inc(tp_pkg::CLK7_HZ, ACC_W));
  localparam logic [ACC_W-1:0] INC_MIN =
    ACC_W'(tp_pkg::nco_inc(tp_pkg::VAR_MIN_HZ, ACC_W));
  localparam logic [ACC_W-1:0] INC_MAX =
    ACC_W'(tp_pkg::nco_inc(tp_pkg::VAR_MAX_HZ, ACC_W));

  //--------------------------------------------------
  // Declarations
  //--------------------------------------------------
  tp_pkg::phase_type    phase_q;
  logic [7:0]           pin_meta_q;
  logic [7:0]           pin_sync_q;
  logic [7:0]           strap_q;
  logic [2:0]           scen_q;
  logic [7:0]           level_q;
  logic [ACC_W-1:0]     var_inc_q;
  logic [ACC_W-1:0]     var_inc_d;
  logic [ACC_W-1:0]     acc_q [4];
  logic [ACC_W-1:0]     inc [4];
  logic [3:0]           dbg_clk;
  logic                 access;
  logic                 wr_en;
  logic                 addr_ok;
  logic [31:0]          rd_d;
  tp_pkg::tp_drive_type drive_d;
  logic [7:0]           clk_pins;

  //--------------------------------------------------
  // Pin synchroniser
  //--------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 8'h00;
    end else begin
      pin_meta_q <= test_point_port_i;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_q <= 8'h00;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  //--------------------------------------------------
  // Reset release sequence
  //--------------------------------------------------
  // Reset low holds the whole port idle until release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= tp_pkg::PH_SETTLE_A;
    end else begin
      case (phase_q)
        tp_pkg::PH_SETTLE_A: begin
          phase_q <= tp_pkg::PH_SETTLE_B;
        end
        tp_pkg::PH_SETTLE_B: begin
          phase_q <= tp_pkg::PH_CAPTURE;
        end
        tp_pkg::PH_CAPTURE: begin
          phase_q <= tp_pkg::PH_RUN;
        end
        default: begin
          phase_q <= tp_pkg::PH_RUN;
        end
      endcase
    end
  end

  // Captured once per release, frozen while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= 8'h00;
    end else if (phase_q == tp_pkg::PH_CAPTURE) begin
      strap_q <= pin_sync_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_valid <= 1'b0;
    end else begin
      strap_valid <= (phase_q == tp_pkg::PH_CAPTURE) | strap_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_option <= 4'h0;
    end else if (phase_q == tp_pkg::PH_CAPTURE) begin
      mode_option <= pin_sync_q[tp_pkg::MODE_LSB +: tp_pkg::MODE_W];
    end
  end

  // Pulldowns stay on at all times
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_down_en <= tp_pkg::ALL_PINS;
    end else begin
      pull_down_en <= tp_pkg::ALL_PINS;
    end
  end

  //--------------------------------------------------
  // APB slave, one wait state
  //--------------------------------------------------
  assign access = psel & penable;
  assign wr_en  = access & pready & pwrite & (phase_q == tp_pkg::PH_RUN);

  always_comb begin
    addr_ok = 1'b1;
    rd_d    = 32'h0000_0000;
    if (paddr == tp_pkg::ADDR_SCEN) begin
      rd_d[2:0] = scen_q;
    end else if (paddr == tp_pkg::ADDR_STRAP) begin
      rd_d[7:0] = strap_q;
      rd_d[8]   = strap_valid;
    end else if (paddr == tp_pkg::ADDR_VAR) begin
      rd_d[ACC_W-1:0] = var_inc_q;
    end else if (paddr == tp_pkg::ADDR_PINS) begin
      rd_d[7:0]  = pin_sync_q;
      rd_d[15:8] = test_point_port.oe;
    end else if (paddr == tp_pkg::ADDR_LEVEL) begin
      rd_d[7:0] = level_q;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access & ~pready & ~pwrite) begin
      prdata <= rd_d;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  //--------------------------------------------------
  // Software registers
  //--------------------------------------------------
  // Strap reload wins; software may change it afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scen_q <= tp_pkg::SCEN_QUIET;
    end else if (phase_q == tp_pkg::PH_CAPTURE) begin
      scen_q <= pin_sync_q[tp_pkg::SCEN_LSB +: tp_pkg::SCEN_W];
    end else if (wr_en && paddr == tp_pkg::ADDR_SCEN) begin
      scen_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 8'h00;
    end else if (wr_en && paddr == tp_pkg::ADDR_LEVEL) begin
      level_q <= pwdata[7:0];
    end
  end

  // Variable clock kept inside its legal range
  always_comb begin
    var_inc_d = pwdata[ACC_W-1:0];
    if (var_inc_d < INC_MIN) begin
      var_inc_d = INC_MIN;
    end else if (var_inc_d > INC_MAX) begin
      var_inc_d = INC_MAX;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      var_inc_q <= INC_MAX;
    end else if (wr_en && paddr == tp_pkg::ADDR_VAR) begin
      var_inc_q <= var_inc_d;
    end
  end

  //--------------------------------------------------
  // Debug clock generators
  //--------------------------------------------------
  assign inc[0] = INC0;
  assign inc[1] = INC1;
  assign inc[2] = var_inc_q;
  assign inc[3] = INC7;

  for (genvar ch = 0; ch < 4; ch++) begin : g_nco
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_q[ch] <= '0;
      end else begin
        acc_q[ch] <= acc_q[ch] + inc[ch];
      end
    end
    assign dbg_clk[ch] = acc_q[ch][ACC_W-1];
  end

  //--------------------------------------------------
  // Output selection
  //--------------------------------------------------
  assign clk_pins = {dbg_clk[3], 4'h0, dbg_clk[2], dbg_clk[1], dbg_clk[0]};

  always_comb begin
    drive_d.oe = tp_pkg::NO_PINS;
    drive_d.o  = 8'h00;
    if (phase_q == tp_pkg::PH_RUN) begin
      case (scen_q)
        tp_pkg::SCEN_CLKDBG: begin
          drive_d.oe = tp_pkg::ALL_PINS;
          drive_d.o  = (tp_pkg::CLKDBG_LEVEL & ~tp_pkg::CLKDBG_CLKS)
                     | (clk_pins & tp_pkg::CLKDBG_CLKS);
        end
        tp_pkg::SCEN_SOFT: begin
          drive_d.oe = tp_pkg::ALL_PINS;
          drive_d.o  = level_q;
        end
        default: begin
          drive_d.oe = tp_pkg::NO_PINS;
          drive_d.o  = 8'h00;
        end
      endcase
    end
  end

  // Inputs until the strap is taken; driven after it only in the clock debug and software scenarios
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_point_port <= '0;
    end else begin
      test_point_port <= drive_d;
    end
  end

endmodule

// ---- core/tp_pkg.sv ----
// Constants and types of the test point strap and debug port
package tp_pkg;
  localparam longint PCLK_HZ = 64'd100_000_000;
  localparam int     TP_W    = 8;
  localparam int     ADDR_W  = 12;
  // Register byte offsets
  localparam logic [11:0] ADDR_SCEN  = 12'h000;
  localparam logic [11:0] ADDR_STRAP = 12'h004;
  localparam logic [11:0] ADDR_VAR   = 12'h008;
  localparam logic [11:0] ADDR_PINS  = 12'h00c;
  localparam logic [11:0] ADDR_LEVEL = 12'h010;
  // Strap fields
  localparam int SCEN_LSB = 0;
  localparam int SCEN_W   = 3;
  localparam int MODE_LSB = 3;
  localparam int MODE_W   = 4;
  // Output scenarios
  localparam logic [2:0] SCEN_QUIET  = 3'h0;
  localparam logic [2:0] SCEN_CLKDBG = 3'h2;
  localparam logic [2:0] SCEN_SOFT   = 3'h7;
  // Clock debug levels and clock pin mask
  localparam logic [7:0] CLKDBG_LEVEL = 8'h68;
  localparam logic [7:0] CLKDBG_CLKS  = 8'h87;
  localparam logic [7:0] ALL_PINS     = 8'hff;
  localparam logic [7:0] NO_PINS      = 8'h00;
  // Debug clock rates
  localparam longint CLK0_HZ    = 64'd60_000_000;
  localparam longint CLK1_HZ    = 64'd30_000_000;
  localparam longint VAR_MIN_HZ = 64'd700_000;
  localparam longint VAR_MAX_HZ = 64'd22_500_000;
  localparam longint CLK7_HZ    = 64'd7_500_000;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] o;
  } tp_drive_type;

  typedef enum logic [1:0] {
    PH_SETTLE_A = 2'b00,
    PH_SETTLE_B = 2'b01,
    PH_CAPTURE  = 2'b10,
    PH_RUN      = 2'b11
  } phase_type;

  // Phase increment; rates above half the clock saturate to half rate
  function automatic longint nco_inc(longint f_hz, int acc_w);
    longint full;
    full = 64'd1 << acc_w;
    if (2 * f_hz >= PCLK_HZ) begin
      return full / 2;
    end
    return (f_hz * full) / PCLK_HZ;
  endfunction
endpackage

// ---- tb/strap_board.sv ----
// Board straps and probe on the test point pins
`timescale 1ns/1ps
module strap_board (
  // Board side
  input wire logic [7:0]           strap_up,
  // Device side
  input wire tp_pkg::tp_drive_type drive,
  input wire logic [7:0]           pull_down_en,
  output logic     [7:0]           pin_level
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drive.oe[i]) begin
        pin_level[i] = drive.o[i];
      end else if (strap_up[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = !pull_down_en[i];
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Testbench of the test point port
`timescale 1ns/1ps
module testbench;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [7:0]           pins, pull_down_en, straps, prev;
  logic [3:0]           mode_option;
  logic                 strap_valid;
  tp_pkg::tp_drive_type tp;
  int                   num_errors, checked;
  int                   n[8];

  test_point_strap_debug_port #(.ACC_W(24)) test_point_strap_debug_port_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .test_point_port_i(pins), .test_point_port(tp), .pull_down_en,
    .mode_option, .strap_valid);
  strap_board strap_board_inst (.strap_up(straps), .drive(tp), .pull_down_en,
    .pin_level(pins));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic close_out;
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stall(input int i);
    if (i == 20) begin
      num_errors++;
      close_out();
    end
  endtask

  // APB transfer, answer left in rd and er
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (i < 20 && pready !== 1'b1);
    if (pready !== 1'b1) begin
      stall(20);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic [7:0] s);
    int i;
    @(posedge pclk);
    straps <= s;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 20 && strap_valid !== 1'b1; i++) @(posedge pclk);
    stall(i);
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    num_errors = 0;
    checked = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, straps} = '0;
    do_reset(8'h00);
    cmp(32'(tp.oe), 32'h0);
    cmp(32'(mode_option), 32'h0);
    apb(1'b0, tp_pkg::ADDR_STRAP, 32'h0);
    cmp(rd, 32'h100);
    straps <= 8'h07;
    repeat (5) @(posedge pclk);
    apb(1'b0, tp_pkg::ADDR_STRAP, 32'h0);
    cmp(rd, 32'h100);
    cmp(32'(tp.oe), 32'h0);
    apb(1'b1, tp_pkg::ADDR_LEVEL, 32'ha5);
    apb(1'b1, tp_pkg::ADDR_SCEN, 32'h7);
    repeat (2) @(posedge pclk);
    cmp({16'h0, tp}, 32'hffa5);
    apb(1'b0, 12'h020, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    apb(1'b0, tp_pkg::ADDR_VAR, 32'h0);
    cmp(rd, 32'h0039_9999);
    apb(1'b1, tp_pkg::ADDR_VAR, 32'h0);
    apb(1'b0, tp_pkg::ADDR_VAR, 32'h0);
    cmp(rd, 32'h0001_cac0);
    apb(1'b1, tp_pkg::ADDR_VAR, 32'h0039_9999);
    do_reset(8'h7a);
    cmp(32'(mode_option), 32'hf);
    apb(1'b0, tp_pkg::ADDR_SCEN, 32'h0);
    cmp(rd, 32'h2);
    cmp(32'(tp.oe), 32'hff);
    cmp(32'(tp.o[6:3]), 32'hd);
    prev = tp.o;
    repeat (60) begin
      @(posedge pclk);
      for (int b = 0; b < 8; b++) n[b] += int'(tp.o[b] !== prev[b]);
      prev = tp.o;
    end
    cmp(32'(n[0]), 32'd60);
    cmp(32'(n[1] inside {35, 36, 37}), 32'h1);
    cmp(32'(n[2] inside {26, 27, 28}), 32'h1);
    cmp(32'(n[7] inside {8, 9, 10}), 32'h1);
    cmp(32'(n[3] + n[4] + n[5] + n[6]), 32'h0);
    apb(1'b1, tp_pkg::ADDR_SCEN, 32'h0);
    repeat (2) @(posedge pclk);
    cmp(32'(tp.oe), 32'h0);
    close_out();
  end
endmodule

// ---- tb/tp_monitor.sv ----
// Checker of the test point port
`timescale 1ns/1ps
module tp_monitor #(
  parameter int ACC_W = 24
) (
  // Watched ports
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [7:0]           test_point_port_i,
  input wire tp_pkg::tp_drive_type test_point_port,
  input wire logic [7:0]           pull_down_en,
  input wire logic [3:0]           mode_option,
  input wire logic                 strap_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pins_input: assert property ($rose(presetn) |-> (test_point_port.oe == 8'h00)[*3])
    else $error("pins driven before capture");
  chk_strap_delay: assert property ($rose(presetn) |-> !strap_valid[*3] ##1 strap_valid)
    else $error("strap capture late or early");
  chk_strap_hold: assert property (strap_valid |=> strap_valid && $stable(mode_option))
    else $error("strap changed after capture");
  chk_pulldown_on: assert property (pull_down_en == 8'hff)
    else $error("pulldowns off");
  chk_default_quiet: assert property ($rose(strap_valid) &&
    $past(test_point_port_i[2:0], 3) == 3'h0 |=> test_point_port.oe == 8'h00)
    else $error("default strap pattern drives pins");
  chk_clkdbg_levels: assert property ($rose(strap_valid) &&
    $past(test_point_port_i[2:0], 3) == 3'h2 |=>
    test_point_port.oe == 8'hff && test_point_port.o[6:3] == 4'hd)
    else $error("clock debug levels wrong after capture");
  chk_ready_wait: assert property (psel && !penable |-> ##1 !pready ##1 pready)
    else $error("ready timing wrong");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  cover property ($rose(strap_valid));
  cover property (pslverr);
  cover property (test_point_port.oe == 8'hff);
endmodule

bind test_point_strap_debug_port tp_monitor #(.ACC_W(ACC_W)) tp_monitor_inst (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .test_point_port_i, .test_point_port, .pull_down_en, .mode_option, .strap_valid);
